// ===== hdl/ppfs_map.vh
// port pin function select: register offsets, fields, reset values
// assumes a 32-bit avalon-mm slave with word addressing by byte offset
`ifndef PPFS_MAP_VH
`define PPFS_MAP_VH
`define PPFS_OFS_P1_DIR   4'h0
`define PPFS_OFS_P1FSEL   4'h1
`define PPFS_OFS_P2_DIR   4'h2
`define PPFS_OFS_P2FSEL   4'h3
`define PPFS_OFS_ANCTL    4'h4
`define PPFS_OFS_P1OUT    4'h5
`define PPFS_OFS_P2OUT    4'h6
`define PPFS_OFS_PININ    4'h7
`define PPFS_ANCTL_AE_LSB 0
`define PPFS_ANCTL_OPS    5
`define PPFS_ANCTL_LCD    6
`define PPFS_RST_BYTE     8'h00
`define PPFS_RST_ANCTL    7'h00
`endif

// ===== hdl/ppfs_pin.v
// one digital pad slot: general i/o, peripheral or driven ground by direction and select
// assumes the caller applies analog and lcd overrides afterwards
`timescale 1ns/100ps
module ppfs_pin
(
    // control
    input  wire dir_bit,
    input  wire sel_bit,
    input  wire out_bit,
    input  wire periph_out,
    input  wire has_periph,
    // pad side
    output wire pad_out,
    output wire pad_oe,
    output wire periph_in_en
);
    // select 0 is plain i/o; select 1 output is peripheral or digital ground
    assign pad_out      = sel_bit ? (has_periph ? periph_out : 1'b0) : out_bit;
    assign pad_oe       = dir_bit;
    assign periph_in_en = sel_bit & ~dir_bit & has_periph;
endmodule // ppfs_pin

// ===== hdl/ppfs_top.v
// pin function mux for port 1 bits 3..7 and port 2 bits 0..7, avalon-mm registers
// assumes asynchronous pad inputs pass two flops here; analog paths are control enables only
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "ppfs_map.vh"
// Operation
// - select picks gpio or timer function: capture/compare on p1.3, clock in/aux clock out on p1.5
// - no peripheral: select with output drives ground
// - analog enable: converter input, driver and trigger off
// - p1.4: converter output beats analog, then gpio
// - converter output disables driver and schmitt trigger
// - negative inputs tie to analog ground when clear
// - p1.6 gpio or pair two negative input
// - lcd enable makes port 2 segments 13..6
// - reset restores general i/o on every pin
module ppfs_top
(
    // clock and reset
    input  wire        mclk,
    input  wire        reset,
    // avalon-mm slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // peripherals
    input  wire        timer_compare2_output,
    input  wire        aux_clock,
    input  wire [7:0]  lcd_segment_data,
    output wire        timer_capture2_input_a,
    output wire        timer_external_clock_input,
    output wire        timer_inverted_clock_input,
    // converter routing enables
    output wire        analog_pair4_positive,
    output wire        analog_pair_three_positive,
    output wire        analog_pair_two_positive,
    output wire        analog_pair_three_negative,
    output wire        analog_pair_two_negative,
    output wire        neg3_to_analog_ground_level,
    output wire        neg2_to_analog_ground_level,
    output wire        converter_analog_output,
    // port 1 pads, bits 3..7
    input  wire [7:3]  p1_pad_in,
    output wire [7:3]  p1_pad_out,
    output wire [7:3]  p1_pad_oe,
    output wire [7:3]  p1_schmitt_en,
    // port 2 pads
    input  wire [7:0]  p2_pad_in,
    output wire [7:0]  p2_pad_out,
    output wire [7:0]  p2_pad_oe,
    output wire [7:0]  p2_schmitt_en,
    output wire [7:0]  p2_lcd_en
);
    // software-visible control registers
    reg  [7:0]  p1_dir_r;
    reg  [7:0]  p1_sel_r;
    reg  [7:0]  p2_dir_r;
    reg  [7:0]  p2_sel_r;
    reg  [7:0]  p1out_r;
    reg  [7:0]  p2out_r;
    reg  [6:0]  anctl_r;
    // pad level synchroniser, read by the pin-in register and the timer inputs
    reg  [12:0] sync1_r;
    reg  [12:0] sync2_r;
    reg         rd_done_r;

    // decoded control fields and per-slot results
    wire [3:0]  word;
    wire [4:0]  analog_input_enable_bit;
    wire        converter_output_select;
    wire        lcd_segment_group_enable;
    wire [7:3]  d_out;
    wire [7:3]  d_oe;
    wire [7:3]  d_pin;
    wire [7:0]  q_out;
    wire [7:0]  q_oe;
    wire [7:3]  p1_ae;
    wire [7:3]  p1_hasp;
    wire [7:3]  p1_pout;

    assign word                     = avs_address[5:2];
    assign analog_input_enable_bit  = anctl_r[4:0];
    assign converter_output_select  = anctl_r[`PPFS_ANCTL_OPS];
    assign lcd_segment_group_enable = anctl_r[`PPFS_ANCTL_LCD];

    // reads wait one cycle so readdata comes from a flop; writes never wait
    assign avs_waitrequest = avs_read & ~rd_done_r;

    always @(posedge mclk)
    begin
        if (reset)
        begin
            p1_dir_r  <= `PPFS_RST_BYTE;
            p1_sel_r  <= `PPFS_RST_BYTE;
            p2_dir_r  <= `PPFS_RST_BYTE;
            p2_sel_r  <= `PPFS_RST_BYTE;
            p1out_r   <= `PPFS_RST_BYTE;
            p2out_r   <= `PPFS_RST_BYTE;
            anctl_r   <= `PPFS_RST_ANCTL;
            rd_done_r <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            sync1_r   <= 13'h0;
            sync2_r   <= 13'h0;
        end
        else
        begin
            // pads are asynchronous: only the second flop feeds logic
            sync1_r   <= {p2_pad_in, p1_pad_in};
            sync2_r   <= sync1_r;
            rd_done_r <= avs_read & ~rd_done_r;
            // unmapped writes fall through and change nothing
            if (avs_write)
            begin
                case (word)
                    `PPFS_OFS_P1_DIR: p1_dir_r <= avs_writedata[7:0];
                    `PPFS_OFS_P1FSEL: p1_sel_r <= avs_writedata[7:0];
                    `PPFS_OFS_P2_DIR: p2_dir_r <= avs_writedata[7:0];
                    `PPFS_OFS_P2FSEL: p2_sel_r <= avs_writedata[7:0];
                    `PPFS_OFS_ANCTL:  anctl_r <= avs_writedata[6:0];
                    `PPFS_OFS_P1OUT:  p1out_r <= avs_writedata[7:0];
                    `PPFS_OFS_P2OUT:  p2out_r <= avs_writedata[7:0];
                    default:          p1out_r <= p1out_r;
                endcase
            end
            // one fetch per request; readdata then holds until the next read
            if (avs_read & ~rd_done_r)
            begin
                case (word)
                    `PPFS_OFS_P1_DIR: avs_readdata <= {24'h000000, p1_dir_r};
                    `PPFS_OFS_P1FSEL: avs_readdata <= {24'h000000, p1_sel_r};
                    `PPFS_OFS_P2_DIR: avs_readdata <= {24'h000000, p2_dir_r};
                    `PPFS_OFS_P2FSEL: avs_readdata <= {24'h000000, p2_sel_r};
                    `PPFS_OFS_ANCTL:  avs_readdata <= {25'h0, anctl_r};
                    `PPFS_OFS_P1OUT:  avs_readdata <= {24'h000000, p1out_r};
                    `PPFS_OFS_P2OUT:  avs_readdata <= {24'h000000, p2out_r};
                    `PPFS_OFS_PININ:  avs_readdata <= {16'h0000, sync2_r[12:5], sync2_r[4:0], 3'h0};
                    default:          avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // per-pin peripheral availability: only bits 3 and 5 carry timer functions
    assign p1_hasp = 5'b00101;
    assign p1_pout = {2'b00, aux_clock, 1'b0, timer_compare2_output};
    assign p1_ae   = analog_input_enable_bit;

    // one slot per pad; port 2 has no peripheral functions of its own
    genvar i;
    generate
        for (i = 3; i < 8; i = i + 1)
        begin : g_p1
            ppfs_pin u_pin
            (
                .dir_bit      (p1_dir_r[i]),
                .sel_bit      (p1_sel_r[i]),
                .out_bit      (p1out_r[i]),
                .periph_out   (p1_pout[i]),
                .has_periph   (p1_hasp[i]),
                .pad_out      (d_out[i]),
                .pad_oe       (d_oe[i]),
                .periph_in_en (d_pin[i])
            );
        end
        for (i = 0; i < 8; i = i + 1)
        begin : g_p2
            ppfs_pin u_pin
            (
                .dir_bit      (p2_dir_r[i]),
                .sel_bit      (p2_sel_r[i]),
                .out_bit      (p2out_r[i]),
                .periph_out   (1'b0),
                .has_periph   (1'b0),
                .pad_out      (q_out[i]),
                .pad_oe       (q_oe[i]),
                .periph_in_en ()
            );
        end
    endgenerate

    // port 1: analog enable drops driver and schmitt trigger (avoids cross currents)
    assign p1_pad_out[3]   = d_out[3] & ~p1_ae[3];
    assign p1_pad_oe[3]    = d_oe[3] & ~p1_ae[3];
    assign p1_schmitt_en[3] = ~p1_ae[3];
    assign p1_pad_out[5]   = d_out[5] & ~p1_ae[5];
    assign p1_pad_oe[5]    = d_oe[5] & ~p1_ae[5];
    assign p1_schmitt_en[5] = ~p1_ae[5];
    assign p1_pad_out[7]   = d_out[7] & ~p1_ae[7];
    assign p1_pad_oe[7]    = d_oe[7] & ~p1_ae[7];
    assign p1_schmitt_en[7] = ~p1_ae[7];
    // p1.4: converter output has top priority
    assign p1_pad_out[4]   = d_out[4] & ~p1_ae[4] & ~converter_output_select;
    assign p1_pad_oe[4]    = d_oe[4] & ~p1_ae[4] & ~converter_output_select;
    assign p1_schmitt_en[4] = ~p1_ae[4] & ~converter_output_select;
    assign p1_pad_out[6]   = d_out[6] & ~p1_ae[6];
    assign p1_pad_oe[6]    = d_oe[6] & ~p1_ae[6];
    assign p1_schmitt_en[6] = ~p1_ae[6];

    // timer inputs read the synchronised pad only while the function is selected
    // limitation: the timer sees a pad edge two cycles late
    assign timer_capture2_input_a     = d_pin[3] & ~p1_ae[3] & sync2_r[0];
    assign timer_external_clock_input = d_pin[5] & ~p1_ae[5] & sync2_r[2];
    assign timer_inverted_clock_input = d_pin[5] & ~p1_ae[5] & ~sync2_r[2];

    // converter routing; ground ties stay on so an unused negative input never floats
    assign analog_pair4_positive       = p1_ae[3];
    assign analog_pair_three_positive  = p1_ae[5];
    assign analog_pair_two_positive    = p1_ae[7];
    assign analog_pair_three_negative  = p1_ae[4] & ~converter_output_select;
    assign analog_pair_two_negative    = p1_ae[6];
    assign neg3_to_analog_ground_level = ~analog_pair_three_negative;
    assign neg2_to_analog_ground_level = ~p1_ae[6];
    assign converter_analog_output     = converter_output_select;

    // lcd enable wins over direction and select on every port 2 pin
    // port 2: lcd takes every pin, bit 0 segment 13 down to bit 7 segment 6
    assign p2_pad_out    = lcd_segment_group_enable ? lcd_segment_data : q_out;
    assign p2_pad_oe     = lcd_segment_group_enable ? 8'hff : q_oe;
    assign p2_schmitt_en = lcd_segment_group_enable ? 8'h00 : 8'hff;
    assign p2_lcd_en     = {8{lcd_segment_group_enable}};
endmodule // ppfs_top

// ===== testbench/ppfs_properties.sv
// checker for the pin function mux, port relations only
// assumes the top module ports as declared; bound below
`timescale 1ns/100ps
module ppfs_props
(
    // clock, reset, bus
    input  wire        mclk, reset, avs_write, avs_read, avs_waitrequest,
    input  wire [5:0]  avs_address,
    input  wire [31:0] avs_writedata,
    // routing
    input  wire        analog_pair4_positive, analog_pair_three_negative, analog_pair_two_negative,
    input  wire        neg3_to_analog_ground_level, neg2_to_analog_ground_level, converter_analog_output,
    input  wire [7:3]  p1_pad_oe, p1_schmitt_en,
    input  wire [7:0]  lcd_segment_data, p2_pad_out, p2_pad_oe, p2_lcd_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_ops_off; converter_analog_output |-> !p1_pad_oe[4] && !p1_schmitt_en[4]; endproperty
    a_ops_off: assert property (p_ops_off) else $error("converter pin driver on");
    property p_ops_neg; converter_analog_output |-> !analog_pair_three_negative; endproperty
    a_ops_neg: assert property (p_ops_neg) else $error("negative input beside converter");
    property p_tie3; neg3_to_analog_ground_level != analog_pair_three_negative; endproperty
    a_tie3: assert property (p_tie3) else $error("pair three ground tie wrong");
    property p_tie2; neg2_to_analog_ground_level != analog_pair_two_negative; endproperty
    a_tie2: assert property (p_tie2) else $error("pair two ground tie wrong");
    property p_ae3; analog_pair4_positive |-> !p1_pad_oe[3] && !p1_schmitt_en[3]; endproperty
    a_ae3: assert property (p_ae3) else $error("analog pin driver on");
    property p_ae6; analog_pair_two_negative |-> !p1_pad_oe[6] && !p1_schmitt_en[6]; endproperty
    a_ae6: assert property (p_ae6) else $error("pair two pin driver on");
    property p_lcd; p2_lcd_en[0] |-> p2_lcd_en == 8'hff && p2_pad_oe == 8'hff && p2_pad_out == lcd_segment_data;
    endproperty
    a_lcd: assert property (p_lcd) else $error("segment routing wrong");
    // write lands at its edge, routing follows with no extra cycle
    property p_ops_wr; avs_write && avs_address[5:2] == 4'h4 |=> converter_analog_output == $past(avs_writedata[5]);
    endproperty
    a_ops_wr: assert property (p_ops_wr) else $error("routing late after write");
    property p_rst; disable iff (1'b0) reset |=> !p1_pad_oe && !p2_pad_oe && !p2_lcd_en; endproperty
    a_rst: assert property (p_rst) else $error("reset left a pad driven");
    c_lcd: cover property (p2_lcd_en[0]);
    c_ops: cover property (converter_analog_output);
    c_rd: cover property (avs_read && !avs_waitrequest);
endmodule // ppfs_props
bind ppfs_top ppfs_props chk_i(.mclk, .reset, .avs_write, .avs_read, .avs_waitrequest, .avs_address,
    .avs_writedata, .analog_pair4_positive, .analog_pair_three_negative, .analog_pair_two_negative,
    .neg3_to_analog_ground_level, .neg2_to_analog_ground_level, .converter_analog_output, .p1_pad_oe,
    .p1_schmitt_en, .lcd_segment_data, .p2_pad_out, .p2_pad_oe, .p2_lcd_en);

// ===== testbench/ppfs_pads.sv
// pad model: a driven pad reads its own level, else the outside level
// assumes the bench sets the outside level; no pulls on these pads
`timescale 1ns/100ps
module ppfs_pads
(
    // device side
    input  wire [7:3] p1_pad_out, p1_pad_oe, ext1,
    input  wire [7:0] p2_pad_out, p2_pad_oe, ext2,
    // wire levels
    output wire [7:3] p1_pad_in,
    output wire [7:0] p2_pad_in
);
    assign p1_pad_in = (p1_pad_oe & p1_pad_out) | (~p1_pad_oe & ext1);
    assign p2_pad_in = (p2_pad_oe & p2_pad_out) | (~p2_pad_oe & ext2);
endmodule // ppfs_pads

// ===== testbench/ppfs_top_tb.sv
// bench for the pin function mux: bus tasks, scenarios, verdict
// assumes ppfs_pads closes the pad loop and the checker is bound
`timescale 1ns/100ps
module ppfs_top_tb;
    reg         mclk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    reg  [5:0]  avs_address = 6'h00;
    reg  [31:0] avs_writedata = 32'h0, r;
    reg         timer_compare2_output = 1'b0, aux_clock = 1'b0;
    reg  [7:0]  lcd_segment_data = 8'h00, ext2 = 8'h00;
    reg  [7:3]  ext1 = 5'h00;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, timer_capture2_input_a, timer_external_clock_input, timer_inverted_clock_input;
    wire        analog_pair4_positive, analog_pair_three_positive, analog_pair_two_positive, converter_analog_output;
    wire        analog_pair_three_negative, analog_pair_two_negative, neg3_to_analog_ground_level, neg2_to_analog_ground_level;
    wire [7:3]  p1_pad_in, p1_pad_out, p1_pad_oe, p1_schmitt_en;
    wire [7:0]  p2_pad_in, p2_pad_out, p2_pad_oe, p2_schmitt_en, p2_lcd_en;
    integer     n_errors = 0, cmp_count = 0, cyc = 0, i;
    ppfs_top uut(.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .timer_compare2_output, .aux_clock, .lcd_segment_data, .timer_capture2_input_a, .timer_external_clock_input,
        .timer_inverted_clock_input, .analog_pair4_positive, .analog_pair_three_positive, .analog_pair_two_positive,
        .analog_pair_three_negative, .analog_pair_two_negative, .neg3_to_analog_ground_level,
        .neg2_to_analog_ground_level, .converter_analog_output, .p1_pad_in, .p1_pad_out, .p1_pad_oe, .p1_schmitt_en,
        .p2_pad_in, .p2_pad_out, .p2_pad_oe, .p2_schmitt_en, .p2_lcd_en);
    ppfs_pads pads(.p1_pad_out, .p1_pad_oe, .ext1, .p2_pad_out, .p2_pad_oe, .ext2, .p1_pad_in, .p2_pad_in);
    initial forever #2.5 mclk = ~mclk;
    task close_out;
    begin
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    task chk(input [31:0] g, input [31:0] e);
    begin
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    // request held until waitrequest is seen low at an edge
    task bus(input w, input [5:0] a, input [31:0] d);
    begin
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge mclk);
    end
    endtask
    task rst(input integer n);
    begin
        @(posedge mclk);
        reset <= 1'b1;
        repeat (n) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
    end
    endtask
    task s_default;
    begin
        chk({p1_pad_oe, p2_pad_oe, p2_lcd_en}, 0);
        chk({p1_schmitt_en, p2_schmitt_en, converter_analog_output, neg3_to_analog_ground_level}, 15'h7ffd);
        for (i = 0; i < 7; i = i + 1)
        begin
            bus(1'b0, i * 4, 0);
            chk(r, 0);
        end
        bus(1'b0, 6'h3c, 0);
        chk(r, 0);
    end
    endtask
    task s_timer;
    begin
        bus(1'b1, 6'h00, 32'h28);
        bus(1'b1, 6'h04, 32'h28);
        @(posedge mclk);
        timer_compare2_output <= 1'b1;
        aux_clock <= 1'b1;
        @(negedge mclk);
        chk({p1_pad_oe[5], p1_pad_oe[3], p1_pad_out[5], p1_pad_out[3]}, 4'hf);
        bus(1'b1, 6'h00, 0);
        @(posedge mclk);
        ext1 <= 5'h05;
        repeat (3) @(negedge mclk);
        chk({p1_pad_oe, timer_capture2_input_a, timer_external_clock_input}, 7'h03);
        chk(timer_inverted_clock_input, 0);
        bus(1'b0, 6'h1c, 0);
        chk(r, 32'h28);
        @(posedge mclk);
        ext1 <= 5'h00;
        repeat (3) @(negedge mclk);
        chk({timer_capture2_input_a, timer_external_clock_input, timer_inverted_clock_input}, 3'h1);
        bus(1'b1, 6'h04, 0);
        bus(1'b1, 6'h00, 32'hf8);
        bus(1'b1, 6'h14, 32'ha8);
        chk({p1_pad_oe, p1_pad_out}, 10'h3f5);
    end
    endtask
    task s_ground;
    begin
        bus(1'b1, 6'h00, 32'hd0);
        bus(1'b1, 6'h04, 32'hd0);
        bus(1'b1, 6'h08, 32'hff);
        bus(1'b1, 6'h0c, 32'hff);
        bus(1'b1, 6'h18, 32'hff);
        chk({p1_pad_oe[7:6], p1_pad_oe[4], p1_pad_out[7:6], p1_pad_out[4]}, 6'h38);
        chk({p2_pad_oe, p2_pad_out}, 16'hff00);
    end
    endtask
    task s_analog;
    begin
        bus(1'b1, 6'h10, 32'h1f);
        chk({p1_pad_oe, p1_schmitt_en}, 0);
        chk({analog_pair4_positive, analog_pair_two_negative, neg2_to_analog_ground_level}, 3'h6);
        chk({analog_pair4_positive, analog_pair_three_positive, analog_pair_two_positive}, 3'h7);
        chk({analog_pair_three_negative, neg3_to_analog_ground_level}, 2'h2);
        bus(1'b1, 6'h10, 32'h20);
        chk({converter_analog_output, analog_pair_three_negative, neg3_to_analog_ground_level}, 3'h5);
        chk({p1_pad_oe[6], p1_pad_oe[4], p1_schmitt_en[4]}, 3'h4);
        bus(1'b1, 6'h10, 32'h22);
        chk({converter_analog_output, analog_pair_three_negative}, 2'h2);
        bus(1'b1, 6'h10, 32'h02);
        chk({converter_analog_output, analog_pair_three_negative, p1_pad_oe[4]}, 3'h2);
    end
    endtask
    task s_lcd;
    begin
        @(posedge mclk);
        lcd_segment_data <= 8'h96;
        bus(1'b1, 6'h10, 32'h40);
        chk({p2_lcd_en, p2_pad_out, p2_pad_oe, p2_schmitt_en}, 32'hff96ff00);
        repeat (2) @(negedge mclk);
        bus(1'b0, 6'h1c, 0);
        chk(r, 32'h9600);
        bus(1'b1, 6'h10, 0);
        chk({p2_lcd_en, p2_pad_oe}, 16'h00ff);
    end
    endtask
    initial
    begin
        rst(20);
        s_default;
        s_timer;
        s_ground;
        s_analog;
        s_lcd;
        rst(2);
        s_default;
        close_out;
    end
endmodule // ppfs_top_tb
